// ===== rtl/bcc_conv_ctrl.sv
// Operation
// - rate field, reset 000, selects one-shot/power-down or 1 to 200 Hz
// - at 100 Hz or 200 Hz low-noise is forced off
// - rate 000 is power-down: no acquisitions except one-shot, outputs frozen otherwise, registers kept
// - one-shot write starts one acquisition in power-down only, bit self-clears when the acquisition completes, even while hold keeps outputs frozen
// - nonzero rate acquires repeatedly at the selected rate
// - filter off gives OUTPUT_RATE_SELECT/2, enabled gives OUTPUT_RATE_SELECT/9 or OUTPUT_RATE_SELECT/20
// - hold mode freezes pressure outputs until the high byte of the sample is read
// - wire select bit: 0 four-wire SPI, 1 three-wire SPI
// - interrupt polarity bit: 0 active high, 1 active low
// - interrupt drive bit: 0 push-pull, 1 open-drain
// - auto-increment bit, reset 1, advances address after each byte
// - low-noise bit selects low-noise only below 100 Hz
// - boot bit reloads trim values, cleared by hardware when done
// - soft reset returns volatile registers to defaults and self-clears
`timescale 1ns/1ps
`default_nettype none
`include "bcc_defs.svh"

module bcc_conv_ctrl #(
    parameter logic [23:0] P_CYC_1HZ   = 24'(`BCC_PER_1HZ_US * `BCC_CLK_MHZ),
    parameter logic [23:0] P_CYC_10HZ  = 24'(`BCC_PER_10HZ_US * `BCC_CLK_MHZ),
    parameter logic [23:0] P_CYC_25HZ  = 24'(`BCC_PER_25HZ_US * `BCC_CLK_MHZ),
    parameter logic [23:0] P_CYC_50HZ  = 24'(`BCC_PER_50HZ_US * `BCC_CLK_MHZ),
    parameter logic [23:0] P_CYC_75HZ  = 24'(`BCC_PER_75HZ_US * `BCC_CLK_MHZ),
    parameter logic [23:0] P_CYC_100HZ = 24'(`BCC_PER_100HZ_US * `BCC_CLK_MHZ),
    parameter logic [23:0] P_CYC_200HZ = 24'(`BCC_PER_200HZ_US * `BCC_CLK_MHZ)
) (
    // clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_rst_n,
    // serial front end byte port
    input  wire logic        i_start,
    input  wire logic [7:0]  i_start_addr,
    input  wire logic        i_wr_en,
    input  wire logic [7:0]  i_wdata,
    input  wire logic        i_rd_en,
    output logic      [7:0]  o_rdata,
    output logic             o_rdata_valid,
    // acquisition engine
    output logic             o_acq_start,
    input  wire logic        i_acq_done,
    input  wire logic [23:0] i_acq_press,
    // analog and pad configuration
    output logic             o_power_down,
    output logic             o_low_noise,
    output logic      [1:0]  o_filter_bw,
    output logic             o_spi_3wire,
    output logic             o_trim_reload,
    // interrupt pad
    input  wire logic        i_irq_event,
    output logic             o_irq_o,
    output logic             o_irq_oe
);

    logic [7:0]  ctrl1_r, ctrl1_nxt;
    logic [7:0]  ctrl2_r, ctrl2_nxt;
    logic [7:0]  ptr_r, ptr_nxt;
    logic [7:0]  rdata_r, rdata_nxt;
    logic        rvalid_r;
    logic [23:0] press_r, press_nxt;
    logic [23:0] pend_r, pend_nxt;
    logic        pend_v_r, pend_v_nxt;
    logic        hold_r, hold_nxt;
    logic        run_one_r, run_one_nxt;
    logic        start_r, start_nxt;
    logic        pd_r, pd_nxt;
    logic        ln_r, ln_nxt;
    logic [1:0]  bw_r, bw_nxt;
    logic        irq_o_r, irq_o_nxt;
    logic        irq_oe_r, irq_oe_nxt;
    logic [2:0]  odr_q_r;
    logic [2:0]  output_rate_select;
    logic [23:0] period;
    logic        rate_load, rate_exp, boot_load, boot_exp;
    logic        acc, wr1, wr2, rd_ph, soft_rst, one_set, boot_set;
    logic        one_done, irq_lvl, load_out;
    bcc_pkg::bcc_state_t seq_r, seq_nxt;

    assign output_rate_select   = ctrl1_r[`BCC_ODR_HI:`BCC_ODR_LO];
    assign acc   = (i_wr_en | i_rd_en) & !i_start;
    assign wr1   = i_wr_en & !i_start & (ptr_r == `BCC_ADDR_CTRL1);
    assign wr2   = i_wr_en & !i_start & (ptr_r == `BCC_ADDR_CTRL2);
    assign rd_ph = i_rd_en & !i_start & (ptr_r == `BCC_ADDR_PRESS_H);
    assign soft_rst = wr2 & i_wdata[`BCC_SOFT_RST];
    // one-shot is taken only from power-down; elsewhere the write is dropped
    assign one_set  = wr2 & i_wdata[`BCC_ONE_SHOT] & (output_rate_select == `BCC_ODR_OFF);
    assign boot_set = wr2 & i_wdata[`BCC_BOOT];
    assign boot_load = boot_set & !ctrl2_r[`BCC_BOOT];
    assign one_done = (seq_r == bcc_pkg::BCC_SEQ_BUSY) & i_acq_done & run_one_r;

    // rate period table
    always_comb begin
        case (output_rate_select)
            3'h1:    period = P_CYC_1HZ;
            3'h2:    period = P_CYC_10HZ;
            3'h3:    period = P_CYC_25HZ;
            3'h4:    period = P_CYC_50HZ;
            3'h5:    period = P_CYC_75HZ;
            3'h6:    period = P_CYC_100HZ;
            3'h7:    period = P_CYC_200HZ;
            default: period = '0;
        endcase
    end

    // a rate change restarts the period, so the new rate takes hold at once
    assign rate_load = rate_exp | (output_rate_select != odr_q_r);

    bcc_countdown #(.W(`BCC_CNT_W)) u_rate (
        .i_clk    (i_clk),
        .i_rst_n  (i_rst_n),
        .i_load   (rate_load),
        .i_value  (period),
        .o_expire (rate_exp)
    );

    bcc_countdown #(.W(`BCC_CNT_W)) u_boot (
        .i_clk    (i_clk),
        .i_rst_n  (i_rst_n),
        .i_load   (boot_load),
        .i_value  (`BCC_BOOT_CYC),
        .o_expire (boot_exp)
    );

    // control registers; hardware-cleared bits lose to a same-cycle set
    always_comb begin
        ctrl1_nxt = ctrl1_r;
        ctrl2_nxt = ctrl2_r;
        if (wr1) begin
            ctrl1_nxt = i_wdata & `BCC_CTRL1_MASK;
        end
        if (wr2) begin
            ctrl2_nxt = (i_wdata & `BCC_CTRL2_MASK & ~`BCC_CTRL2_HW_MASK)
                      | (ctrl2_r & `BCC_CTRL2_HW_MASK);
        end
        if (one_done && !one_set) begin
            ctrl2_nxt[`BCC_ONE_SHOT] = 1'b0;
        end
        if (one_set) begin
            ctrl2_nxt[`BCC_ONE_SHOT] = 1'b1;
        end
        if (boot_exp) begin
            ctrl2_nxt[`BCC_BOOT] = 1'b0;
        end
        if (boot_set) begin
            ctrl2_nxt[`BCC_BOOT] = 1'b1;
        end
        if (soft_rst) begin
            ctrl1_nxt = `BCC_CTRL1_RST;
            ctrl2_nxt = `BCC_CTRL2_RST;
        end
    end

    // address pointer and read data
    always_comb begin
        ptr_nxt = ptr_r;
        if (i_start) begin
            ptr_nxt = i_start_addr;
        end else if (acc && ctrl2_r[`BCC_AUTO_INC]) begin
            ptr_nxt = ptr_r + 8'h01;
        end
        case (ptr_r)
            `BCC_ADDR_ID:       rdata_nxt = `BCC_ID_VALUE;
            `BCC_ADDR_CTRL1:    rdata_nxt = ctrl1_r;
            `BCC_ADDR_CTRL2:    rdata_nxt = ctrl2_r;
            `BCC_ADDR_PRESS_XL: rdata_nxt = press_r[7:0];
            `BCC_ADDR_PRESS_L:  rdata_nxt = press_r[15:8];
            `BCC_ADDR_PRESS_H:  rdata_nxt = press_r[23:16];
            default:            rdata_nxt = 8'h00;
        endcase
        if (!(i_rd_en && !i_start)) begin
            rdata_nxt = rdata_r;
        end
    end

    // acquisition sequencer
    always_comb begin
        seq_nxt     = seq_r;
        run_one_nxt = run_one_r;
        start_nxt   = 1'b0;
        case (seq_r)
            bcc_pkg::BCC_SEQ_IDLE: begin
                if (ctrl2_r[`BCC_ONE_SHOT] && output_rate_select == `BCC_ODR_OFF) begin
                    start_nxt   = 1'b1;
                    run_one_nxt = 1'b1;
                    seq_nxt     = bcc_pkg::BCC_SEQ_BUSY;
                end else if (rate_exp && output_rate_select != `BCC_ODR_OFF) begin
                    start_nxt   = 1'b1;
                    run_one_nxt = 1'b0;
                    seq_nxt     = bcc_pkg::BCC_SEQ_BUSY;
                end
            end
            bcc_pkg::BCC_SEQ_BUSY: begin
                // a period that ends while busy is skipped, not queued
                if (i_acq_done) begin
                    seq_nxt = bcc_pkg::BCC_SEQ_IDLE;
                end
            end
            default: seq_nxt = bcc_pkg::BCC_SEQ_IDLE;
        endcase
        if (soft_rst) begin
            seq_nxt     = bcc_pkg::BCC_SEQ_IDLE;
            run_one_nxt = 1'b0;
            start_nxt   = 1'b0;
        end
    end

    // output registers with hold-until-read; newest sample waits in pend_r
    always_comb begin
        press_nxt  = press_r;
        pend_nxt   = pend_r;
        pend_v_nxt = pend_v_r;
        load_out   = 1'b0;
        if (!hold_r || rd_ph) begin
            if (seq_r == bcc_pkg::BCC_SEQ_BUSY && i_acq_done) begin
                press_nxt  = i_acq_press;
                pend_v_nxt = 1'b0;
                load_out   = 1'b1;
            end else if (pend_v_r) begin
                press_nxt  = pend_r;
                pend_v_nxt = 1'b0;
                load_out   = 1'b1;
            end
        end else if (seq_r == bcc_pkg::BCC_SEQ_BUSY && i_acq_done) begin
            pend_nxt   = i_acq_press;
            pend_v_nxt = 1'b1;
        end
        hold_nxt = ctrl1_r[`BCC_HOLD] & (load_out | (hold_r & !rd_ph));
    end

    // configuration outputs and interrupt pad
    always_comb begin
        pd_nxt = (output_rate_select == `BCC_ODR_OFF) && (seq_r == bcc_pkg::BCC_SEQ_IDLE) && !start_r;
        ln_nxt = ctrl2_r[`BCC_LOW_NOISE] && (output_rate_select < `BCC_ODR_100HZ);
        if (!ctrl1_r[`BCC_FLT_EN]) begin
            bw_nxt = bcc_pkg::BCC_BW_ODR2;
        end else if (ctrl1_r[`BCC_FLT_BW]) begin
            bw_nxt = bcc_pkg::BCC_BW_ODR20;
        end else begin
            bw_nxt = bcc_pkg::BCC_BW_ODR9;
        end
        irq_lvl = i_irq_event ^ ctrl2_r[`BCC_IRQ_LOW];
        if (ctrl2_r[`BCC_IRQ_OD]) begin
            // open-drain only ever pulls low
            irq_o_nxt  = 1'b0;
            irq_oe_nxt = !irq_lvl;
        end else begin
            irq_o_nxt  = irq_lvl;
            irq_oe_nxt = 1'b1;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            ctrl1_r   <= `BCC_CTRL1_RST;
            ctrl2_r   <= `BCC_CTRL2_RST;
            ptr_r     <= 8'h00;
            rdata_r   <= 8'h00;
            rvalid_r  <= 1'b0;
            press_r   <= 24'h000000;
            pend_r    <= 24'h000000;
            pend_v_r  <= 1'b0;
            hold_r    <= 1'b0;
            run_one_r <= 1'b0;
            start_r   <= 1'b0;
            seq_r     <= bcc_pkg::BCC_SEQ_IDLE;
            odr_q_r   <= `BCC_ODR_OFF;
            pd_r      <= 1'b1;
            ln_r      <= 1'b0;
            bw_r      <= bcc_pkg::BCC_BW_ODR2;
            irq_o_r   <= 1'b0;
            irq_oe_r  <= 1'b0;
        end else begin
            ctrl1_r   <= ctrl1_nxt;
            ctrl2_r   <= ctrl2_nxt;
            ptr_r     <= ptr_nxt;
            rdata_r   <= rdata_nxt;
            rvalid_r  <= i_rd_en & !i_start;
            press_r   <= press_nxt;
            pend_r    <= pend_nxt;
            pend_v_r  <= pend_v_nxt;
            hold_r    <= hold_nxt;
            run_one_r <= run_one_nxt;
            start_r   <= start_nxt;
            seq_r     <= seq_nxt;
            odr_q_r   <= output_rate_select;
            pd_r      <= pd_nxt;
            ln_r      <= ln_nxt;
            bw_r      <= bw_nxt;
            irq_o_r   <= irq_o_nxt;
            irq_oe_r  <= irq_oe_nxt;
        end
    end

    assign o_rdata       = rdata_r;
    assign o_rdata_valid = rvalid_r;
    assign o_acq_start   = start_r;
    assign o_power_down  = pd_r;
    assign o_low_noise   = ln_r;
    assign o_filter_bw   = bw_r;
    assign o_spi_3wire   = ctrl1_r[`BCC_SPI_3W];
    assign o_trim_reload = ctrl2_r[`BCC_BOOT];
    assign o_irq_o       = irq_o_r;
    assign o_irq_oe      = irq_oe_r;

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    a_ln_forced_off: assert property ((output_rate_select >= `BCC_ODR_100HZ) |=> !o_low_noise)
        else $error("low-noise active at high rate");
    a_ln_follows: assert property ((output_rate_select < `BCC_ODR_100HZ) && ctrl2_r[`BCC_LOW_NOISE] |=> o_low_noise)
        else $error("low-noise not applied");
    a_pd_no_start: assert property ((output_rate_select == `BCC_ODR_OFF) && !ctrl2_r[`BCC_ONE_SHOT] |=> !o_acq_start)
        else $error("acquisition started in power-down");
    a_oneshot_clear: assert property (one_done && !one_set |=> !ctrl2_r[`BCC_ONE_SHOT] && !o_acq_start)
        else $error("one-shot bit not cleared");
    a_cont_start: assert property (rate_exp && output_rate_select != `BCC_ODR_OFF && seq_r == bcc_pkg::BCC_SEQ_IDLE
                                   && !ctrl2_r[`BCC_ONE_SHOT] && !soft_rst |=> o_acq_start)
        else $error("continuous acquisition missed");
    a_filter_bw: assert property (!ctrl1_r[`BCC_FLT_EN] |=> o_filter_bw == bcc_pkg::BCC_BW_ODR2)
        else $error("filter bandwidth wrong");
    a_hold_stable: assert property (hold_r && !rd_ph |=> $stable(press_r))
        else $error("outputs changed while held");
    a_id_const: assert property (i_rd_en && !i_start && ptr_r == `BCC_ADDR_ID
                                 |=> o_rdata_valid && o_rdata == `BCC_ID_VALUE)
        else $error("identity read wrong");
    a_addr_inc: assert property (acc && ctrl2_r[`BCC_AUTO_INC] |=> ptr_r == $past(ptr_r) + 8'h01)
        else $error("address not advanced");
    a_boot_done: assert property ($rose(ctrl2_r[`BCC_BOOT]) |-> ##[49:51] !ctrl2_r[`BCC_BOOT])
        else $error("boot bit not cleared");
    a_soft_rst: assert property (soft_rst |=> ctrl1_r == `BCC_CTRL1_RST && ctrl2_r == `BCC_CTRL2_RST)
        else $error("soft reset did not restore defaults");
    a_zero_bits: assert property (wr1 ##1 1'b1 |-> !ctrl1_r[7])
        else $error("fixed-zero bit set");

    c_one_shot: cover property (one_done);
    c_cont_run: cover property (rate_exp && output_rate_select != `BCC_ODR_OFF ##1 o_acq_start);
    c_hold_unlock: cover property (hold_r && rd_ph && pend_v_r);
    c_boot: cover property ($fell(ctrl2_r[`BCC_BOOT]));

endmodule

`default_nettype wire

// ===== rtl/bcc_defs.svh
`ifndef BCC_DEFS_SVH
`define BCC_DEFS_SVH

// register addresses
`define BCC_ADDR_ID        8'h0f
`define BCC_ADDR_CTRL1     8'h10
`define BCC_ADDR_CTRL2     8'h11
`define BCC_ADDR_PRESS_XL  8'h28
`define BCC_ADDR_PRESS_L   8'h29
`define BCC_ADDR_PRESS_H   8'h2a

// reset values and writable masks
`define BCC_CTRL1_RST      8'h00
`define BCC_CTRL2_RST      8'h10
`define BCC_CTRL1_MASK     8'h7f
`define BCC_CTRL2_MASK     8'hf7
`define BCC_CTRL2_HW_MASK  8'h81
`define BCC_ID_VALUE       8'h5a

// rate_filter_control fields
`define BCC_ODR_HI         6
`define BCC_ODR_LO         4
`define BCC_FLT_EN         3
`define BCC_FLT_BW         2
`define BCC_HOLD           1
`define BCC_SPI_3W         0

// operation_control fields
`define BCC_BOOT           7
`define BCC_IRQ_LOW        6
`define BCC_IRQ_OD         5
`define BCC_AUTO_INC       4
`define BCC_SOFT_RST       2
`define BCC_LOW_NOISE      1
`define BCC_ONE_SHOT       0

// rate codes
`define BCC_ODR_OFF        3'h0
`define BCC_ODR_100HZ      3'h6

// timing
`define BCC_CLK_MHZ        10
`define BCC_PER_1HZ_US     1000000
`define BCC_PER_10HZ_US    100000
`define BCC_PER_25HZ_US    40000
`define BCC_PER_50HZ_US    20000
`define BCC_PER_75HZ_US    13333
`define BCC_PER_100HZ_US   10000
`define BCC_PER_200HZ_US   5000
`define BCC_BOOT_US        5
`define BCC_BOOT_CYC       24'(`BCC_BOOT_US * `BCC_CLK_MHZ)
`define BCC_CNT_W          24

`endif

// ===== rtl/bcc_pkg.sv
package bcc_pkg;

    typedef enum logic [1:0] {
        BCC_SEQ_IDLE = 2'b01,
        BCC_SEQ_BUSY = 2'b10
    } bcc_state_t;

    typedef enum logic [1:0] {
        BCC_BW_ODR2  = 2'h0,
        BCC_BW_ODR9  = 2'h1,
        BCC_BW_ODR20 = 2'h2
    } bcc_bw_t;

endpackage

// ===== rtl/bcc_countdown.sv
`timescale 1ns/1ps
`default_nettype none

module bcc_countdown #(
    parameter int W = 24
) (
    // clock and reset
    input  wire logic         i_clk,
    input  wire logic         i_rst_n,
    // control
    input  wire logic         i_load,
    input  wire logic [W-1:0] i_value,
    // status
    output logic              o_expire
);

    logic [W-1:0] cnt_r;
    logic [W-1:0] cnt_nxt;
    logic         exp_r;
    logic         exp_nxt;

    // a load of zero parks the counter without an expiry
    always_comb begin
        cnt_nxt = cnt_r;
        exp_nxt = 1'b0;
        if (i_load) begin
            cnt_nxt = i_value;
        end else if (cnt_r != '0) begin
            cnt_nxt = cnt_r - W'(1);
            // flagged one count early so the reload edge lands exactly i_value cycles after a load
            exp_nxt = (cnt_r == W'(2));
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            cnt_r <= '0;
            exp_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            exp_r <= exp_nxt;
        end
    end

    assign o_expire = exp_r;

endmodule

`default_nettype wire

// ===== dv/bcc_acq_model.sv
`timescale 1ns/1ps
`default_nettype none

// stand-in for the acquisition engine: answers each start after a short or long conversion
module bcc_acq_model (
    // clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_rst_n,
    // handshake with the controller
    input  wire logic        i_start,
    input  wire logic        i_slow,
    output logic             o_done,
    output logic      [23:0] o_press
);
    int unsigned cnt;
    int unsigned left;
    logic        busy;

    // driven on the falling edge so the controller samples settled inputs
    always @(negedge i_clk) begin
        o_done  <= 1'b0;
        // outside the done cycle the bus keeps toggling so a stale sample is never mistaken for data
        o_press <= ~o_press;
        if (!i_rst_n) begin
            busy    <= 1'b0;
            cnt     <= 0;
            o_press <= 24'h0;
        end else if (busy) begin
            if (left == 0) begin
                busy    <= 1'b0;
                o_done  <= 1'b1;
                o_press <= {8'hc3, cnt[7:0], ~cnt[7:0]};
                cnt     <= cnt + 1;
            end else begin
                left <= left - 1;
            end
        end else if (i_start) begin
            busy <= 1'b1;
            left <= i_slow ? 20 : 3;
        end
    end
endmodule

`default_nettype wire

// ===== dv/barometer_conversion_control_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "bcc_defs.svh"

module barometer_conversion_control_test;
    // shortened periods keep every rate inside a short run
    localparam int PER [8] = '{0, 200, 170, 140, 110, 90, 60, 40};
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        start = 1'b0;
    logic [7:0]  start_addr = 8'h00;
    logic        wr_en = 1'b0;
    logic [7:0]  wdata = 8'h00;
    logic        rd_en = 1'b0;
    logic [7:0]  rdata;
    logic        rdata_valid;
    logic        acq_start;
    logic        acq_done;
    logic [23:0] acq_press;
    logic        power_down;
    logic        low_noise;
    logic [1:0]  filter_bw;
    logic        spi_3wire;
    logic        trim_reload;
    logic        irq_event = 1'b0;
    logic        irq_o;
    logic        irq_oe;
    logic        slow = 1'b0;
    int          error_cnt = 0;
    int          compares = 0;
    int          n_done = 0;
    int          boot_cyc = 0;
    int          smp_q[$];
    logic [7:0]  rb[4];

    always #50 clk = ~clk;

    bcc_conv_ctrl #(
        .P_CYC_1HZ   (24'(PER[1])),
        .P_CYC_10HZ  (24'(PER[2])),
        .P_CYC_25HZ  (24'(PER[3])),
        .P_CYC_50HZ  (24'(PER[4])),
        .P_CYC_75HZ  (24'(PER[5])),
        .P_CYC_100HZ (24'(PER[6])),
        .P_CYC_200HZ (24'(PER[7]))
    ) bcc_conv_ctrl_i (
        .i_clk         (clk),
        .i_rst_n       (rst_n),
        .i_start       (start),
        .i_start_addr  (start_addr),
        .i_wr_en       (wr_en),
        .i_wdata       (wdata),
        .i_rd_en       (rd_en),
        .o_rdata       (rdata),
        .o_rdata_valid (rdata_valid),
        .o_acq_start   (acq_start),
        .i_acq_done    (acq_done),
        .i_acq_press   (acq_press),
        .o_power_down  (power_down),
        .o_low_noise   (low_noise),
        .o_filter_bw   (filter_bw),
        .o_spi_3wire   (spi_3wire),
        .o_trim_reload (trim_reload),
        .i_irq_event   (irq_event),
        .o_irq_o       (irq_o),
        .o_irq_oe      (irq_oe)
    );

    bcc_acq_model bcc_acq_model_i (
        .i_clk   (clk),
        .i_rst_n (rst_n),
        .i_start (acq_start),
        .i_slow  (slow),
        .o_done  (acq_done),
        .o_press (acq_press)
    );

    // reference record of every sample handed to the controller
    always @(posedge clk) begin
        if (acq_done === 1'b1) begin
            smp_q.push_back(int'(acq_press));
            n_done++;
        end
    end

    always @(negedge clk) begin
        if (trim_reload === 1'b1)
            boot_cyc++;
    end

    task automatic chk_v(input logic [23:0] got, input logic [23:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic wrap_up();
        $display("counts: %0d compares, %0d mismatches", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic timeout(input string what);
        error_cnt++;
        $display("mismatch at %0t: timeout waiting for %s", $time, what);
        wrap_up();
    endtask

    task automatic fin(input string s);
        $display("test %s finished", s);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        start      = 1'b1;
        start_addr = a;
        @(negedge clk);
        start = 1'b0;
        wr_en = 1'b1;
        wdata = d;
        @(negedge clk);
        wr_en = 1'b0;
        @(negedge clk);
    endtask

    task automatic rd(input logic [7:0] a, input int n);
        @(negedge clk);
        start      = 1'b1;
        start_addr = a;
        @(negedge clk);
        start = 1'b0;
        for (int i = 0; i < n; i++) begin
            rd_en = 1'b1;
            @(negedge clk);
            chk_v(24'(rdata_valid), 24'h1, "read valid");
            rb[i] = rdata;
        end
        rd_en = 1'b0;
    endtask

    // high byte is read last so a held sample is released only after a whole read
    task automatic chk3(input int s);
        rd(8'h28, 3);
        chk_v({rb[2], rb[1], rb[0]}, 24'(s), "pressure bytes");
    endtask

    task automatic wait_idle();
        for (int i = 0; i < 300 && power_down !== 1'b1; i++)
            @(negedge clk);
        if (power_down !== 1'b1)
            timeout("power-down");
    endtask

    task automatic one_shot();
        int n0;
        n0 = n_done;
        wr(8'h11, 8'h11);
        rd(8'h11, 1);
        chk_v(24'(rb[0]), 24'h11, "one-shot bit set");
        for (int i = 0; i < 300 && n_done == n0; i++)
            @(negedge clk);
        if (n_done == n0)
            timeout("one-shot");
        repeat (2) @(negedge clk);
        chk_v(24'(power_down), 24'h1, "back to power-down");
        rd(8'h11, 1);
        chk_v(24'(rb[0]), 24'h10, "one-shot bit cleared");
    endtask

    initial begin
        logic [7:0] d;
        logic       a;
        int         n;
        int         qn;
        void'($urandom(90290));
        repeat (6) @(negedge clk);
        rst_n = 1'b1;
        rd(8'h0f, 3);
        chk_v(24'(rb[0]), 24'(`BCC_ID_VALUE), "identity");
        chk_v(24'(rb[1]), 24'h00, "rate_filter_control reset");
        chk_v(24'(rb[2]), 24'(`BCC_CTRL2_RST), "operation_control reset");
        chk_v(24'({power_down, low_noise, filter_bw, spi_3wire, trim_reload, irq_o, irq_oe}), 24'h81,
              "pins at reset");
        wr(8'h0f, 8'h00);
        wr(8'h20, 8'hff);
        rd(8'h0f, 1);
        chk_v(24'(rb[0]), 24'(`BCC_ID_VALUE), "identity after write");
        rd(8'h20, 1);
        chk_v(24'(rb[0]), 24'h00, "unmapped read");
        fin("reset");
        for (int k = 0; k < 4; k++) begin
            d = (8'($urandom) & 8'h83) | 8'(k << 2);
            wr(8'h10, d);
            rd(8'h10, 1);
            chk_v(24'(rb[0]), 24'(d & 8'h0f), "rate_filter_control readback");
            chk_v(24'(filter_bw), (k == 3) ? 24'h2 : 24'(k >> 1), "filter bandwidth");
            chk_v(24'(spi_3wire), 24'(d[0]), "wire select");
        end
        wr(8'h11, 8'h00);
        rd(8'h0f, 2);
        chk_v(24'(rb[1]), 24'(`BCC_ID_VALUE), "fixed address");
        wr(8'h11, 8'h10);
        fin("registers");
        for (int k = 0; k < 8; k++) begin
            wr(8'h11, 8'h10 | (8'(k % 4) << 5));
            irq_event = 1'($urandom);
            repeat (2) @(negedge clk);
            a = irq_event ^ k[1];
            chk_v(24'({irq_o, irq_oe}), k[0] ? 24'({1'b0, !a}) : 24'({a, 1'b1}), "interrupt pad");
        end
        wr(8'h11, 8'h90);
        for (int i = 0; i < 200 && trim_reload === 1'b1; i++)
            @(negedge clk);
        chk_v(24'(boot_cyc), 24'(`BCC_BOOT_US * `BCC_CLK_MHZ), "boot copy length");
        rd(8'h11, 1);
        chk_v(24'(rb[0]), 24'h10, "boot bit cleared");
        fin("pad and boot");
        wr(8'h11, 8'h12);
        for (int r = 1; r < 8; r++) begin
            wr(8'h10, 8'(r << 4));
            chk_v(24'({low_noise, power_down}), 24'({r < 6, 1'b0}), "low-noise and run state");
            for (n = 0; n < 400 && acq_start !== 1'b1; n++)
                @(negedge clk);
            if (n >= 400)
                timeout("first acquisition");
            for (n = 1; n < 400; n++) begin
                @(negedge clk);
                if (acq_start === 1'b1)
                    break;
            end
            chk_v(24'(n), 24'(PER[r]), "acquisition period");
        end
        wr(8'h10, 8'h00);
        wait_idle();
        wr(8'h11, 8'h10);
        fin("rates");
        slow = 1'b1;
        qn = smp_q.size();
        wr(8'h10, 8'h02);
        one_shot();
        one_shot();
        chk3(smp_q[qn]);
        chk3(smp_q[qn + 1]);
        wr(8'h10, 8'h00);
        one_shot();
        chk3(smp_q[qn + 2]);
        n = n_done;
        repeat (100) @(negedge clk);
        chk_v(24'(n_done), 24'(n), "no acquisition in power-down");
        chk3(smp_q[qn + 2]);
        wr(8'h10, 8'h70);
        wr(8'h11, 8'h11);
        rd(8'h11, 1);
        chk_v(24'(rb[0]), 24'h10, "one-shot refused while running");
        fin("one-shot and hold");
        wr(8'h11, 8'h64);
        rd(8'h10, 2);
        chk_v(24'({rb[0], rb[1]}), 24'h0010, "soft reset");
        wait_idle();
        fin("soft reset");
        wrap_up();
    end
endmodule

`default_nettype wire
